// *** rx_cfg_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RX_CFG_REGS_SVH
`define RX_CFG_REGS_SVH

`define EQ_CTL_ADDR 8'h35
`define STRAP_ADDR 8'h37
`define ACLK_DIV_ADDR 8'h3A
`define EQ_STAT_ADDR 8'h3B
`define LINK_ERR_ADDR 8'h41
`define CC_CFG_ADDR 8'h43
`define EQ_FLOOR_ADDR 8'h45

`define EQ_CTL_RESET 8'h00
`define LINK_ERR_RESET 8'h03
`define CC_CFG_RESET 8'h00
`define EQ_FLOOR_RESET 8'h08
`define ACLK_DIV_RESET 8'h00

`define EQ_RESTART_BIT 6
`define FLOOR_OVR_BIT 5
`define FLOOR_APPLY_BIT 4
`define OUT_DIV_OVR_BIT 7
`define IN_DIV_OVR_BIT 2
`define ERR_CNT_EN_BIT 4

// pixel clocks a strap level must stay steady before it is latched
`define STRAP_SETTLE_CYCLES 16

`endif

// *** rx_cfg_pkg.sv ***
// types shared by the receiver configuration block
package rx_cfg_pkg;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] out_div;
    logic [3:0] in_div;
  } clk_div_t;

  typedef struct packed {
    logic restart;
    logic floor_active;
    logic [3:0] floor_level;
  } eq_ctl_t;

  typedef enum logic [1:0] {
    STRAP_IDLE,
    STRAP_SETTLE,
    STRAP_DONE
  } strap_state_t;

endpackage

// *** strap_decoder.sv ***
// decodes one mode-strap pin level and latches it once
`include "rx_cfg_regs.svh"
module strap_decoder import rx_cfg_pkg::*; #(
  parameter int SETTLE = `STRAP_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [2:0] level_in,
  output logic [2:0] level_q,
  output logic done_q
);
  strap_state_t state_q;
  logic [2:0] seen_q;
  logic [7:0] cnt_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= STRAP_IDLE;
      seen_q <= 3'h0;
      cnt_q <= 8'h00;
      level_q <= 3'h0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        STRAP_IDLE: begin
          seen_q <= level_in;
          cnt_q <= 8'h00;
          state_q <= STRAP_SETTLE;
        end
        STRAP_SETTLE: begin
          if (level_in != seen_q) begin
            seen_q <= level_in;
            cnt_q <= 8'h00;
          end else if (cnt_q == 8'(SETTLE - 1)) begin
            level_q <= seen_q;
            done_q <= 1'b1;
            state_q <= STRAP_DONE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= STRAP_DONE;
        end
      endcase
    end
  end
endmodule

// *** receiver_equalizer_and_link_config.sv ***
// equalizer, strap, clock divider and link error configuration registers
// Functional notes
// - floor apply honoured only under override
// - applied floor feeds equalizer adaptation
// - strap one done flag at bit 7
// - strap one level in bits 6-4
// - strap zero level 2-0, done bit 3
// - out divider follows field only when overridden
// - out divider codes map 32 down to 1
// - in divider follows field only when overridden
// - in divider codes map 1,2,4,8
// - bit 4 enables link error counting
// - pixel clock counter, threshold resets to 3
// - disabled: lose lock on first error
// - floor register four bits, resets to 8
`include "rx_cfg_regs.svh"
module receiver_equalizer_and_link_config #(
  parameter int STRAP_SETTLE = `STRAP_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire rx_cfg_pkg::reg_req_t reg_req,
  input wire logic reg_req_valid,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic [2:0] strap0_pin,
  input wire logic [2:0] strap1_pin,
  input wire logic [5:0] equalizer_setting,
  input wire logic [5:0] auto_out_div,
  input wire logic [3:0] auto_in_div,
  input wire logic clk0_error,
  input wire logic clk1_error,
  input wire logic data_channel_error,
  input wire logic link_locked,
  output rx_cfg_pkg::eq_ctl_t eq_ctl_q,
  output rx_cfg_pkg::clk_div_t clk_div_q,
  output logic [2:0] control_channel_mode_q,
  output logic lock_drop_q
);
  import rx_cfg_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic equalizer_adapt_restart_q;
  logic floor_override_enable_q;
  logic floor_apply_q;
  logic [3:0] equalizer_floor_level_q;
  logic out_divider_override_q;
  logic [2:0] out_divider_ratio_q;
  logic in_divider_override_q;
  logic [1:0] in_divider_ratio_q;
  logic err_count_enable_q;
  logic [3:0] err_threshold_q;
  logic [7:0] cc_cfg_q;
  logic [3:0] err_count_q;
  logic [2:0] strap0_level;
  logic [2:0] strap1_level;
  logic strap0_decode_done;
  logic strap1_decode_done;

  // a write lands on the edge that takes it
  logic wr;
  assign wr = reg_req_valid && reg_req.write;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s0_meta_q, s0_sync_q, s1_meta_q, s1_sync_q;
  logic [2:0] err_meta_q, err_sync_q;
  logic [5:0] eq_meta_q, eq_sync_q;

  // pins and error flags cross in from outside: two flops each
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s0_meta_q <= 3'h0;
      s0_sync_q <= 3'h0;
      s1_meta_q <= 3'h0;
      s1_sync_q <= 3'h0;
      err_meta_q <= 3'h0;
      err_sync_q <= 3'h0;
      eq_meta_q <= 6'h00;
      eq_sync_q <= 6'h00;
    end else if (clk_en) begin
      s0_meta_q <= strap0_pin;
      s0_sync_q <= s0_meta_q;
      s1_meta_q <= strap1_pin;
      s1_sync_q <= s1_meta_q;
      err_meta_q <= {clk0_error, clk1_error, data_channel_error};
      err_sync_q <= err_meta_q;
      eq_meta_q <= equalizer_setting;
      eq_sync_q <= eq_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // strap decoders
  // ----------------------------------------------------------------
  // each decoder latches its pin once it has stayed steady
  strap_decoder #(.SETTLE(STRAP_SETTLE)) u_strap0 (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .level_in(s0_sync_q),
    .level_q(strap0_level),
    .done_q(strap0_decode_done)
  );

  strap_decoder #(.SETTLE(STRAP_SETTLE)) u_strap1 (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .level_in(s1_sync_q),
    .level_q(strap1_level),
    .done_q(strap1_decode_done)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      equalizer_adapt_restart_q <= 1'b0;
      floor_override_enable_q <= 1'b0;
      floor_apply_q <= 1'b0;
    end else if (clk_en && wr && reg_req.addr == `EQ_CTL_ADDR) begin
      // restart stays as written until software clears it
      equalizer_adapt_restart_q <= reg_req.wdata[`EQ_RESTART_BIT];
      floor_override_enable_q <= reg_req.wdata[`FLOOR_OVR_BIT];
      floor_apply_q <= reg_req.wdata[`FLOOR_APPLY_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      equalizer_floor_level_q <= 4'(`EQ_FLOOR_RESET);
    end else if (clk_en && wr && reg_req.addr == `EQ_FLOOR_ADDR) begin
      equalizer_floor_level_q <= reg_req.wdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_divider_override_q <= 1'b0;
      out_divider_ratio_q <= 3'h0;
      in_divider_override_q <= 1'b0;
      in_divider_ratio_q <= 2'h0;
    end else if (clk_en && wr && reg_req.addr == `ACLK_DIV_ADDR) begin
      out_divider_override_q <= reg_req.wdata[`OUT_DIV_OVR_BIT];
      out_divider_ratio_q <= reg_req.wdata[6:4];
      in_divider_override_q <= reg_req.wdata[`IN_DIV_OVR_BIT];
      in_divider_ratio_q <= reg_req.wdata[1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      err_count_enable_q <= 1'b0;
      err_threshold_q <= 4'(`LINK_ERR_RESET);
    end else if (clk_en && wr && reg_req.addr == `LINK_ERR_ADDR) begin
      err_count_enable_q <= reg_req.wdata[`ERR_CNT_EN_BIT];
      err_threshold_q <= reg_req.wdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cc_cfg_q <= `CC_CFG_RESET;
    end else if (clk_en && wr && reg_req.addr == `CC_CFG_ADDR) begin
      // bits 7-5 are reserved and always read zero
      cc_cfg_q <= {3'h0, reg_req.wdata[4:0]};
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // unmapped offsets and reserved bits read back as zero
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    if (reg_req.addr == `EQ_CTL_ADDR) begin
      rdata = {1'b0, equalizer_adapt_restart_q, floor_override_enable_q,
               floor_apply_q, 4'h0};
    end else if (reg_req.addr == `STRAP_ADDR) begin
      rdata = {strap1_decode_done, strap1_level,
               strap0_decode_done, strap0_level};
    end else if (reg_req.addr == `ACLK_DIV_ADDR) begin
      rdata = {out_divider_override_q, out_divider_ratio_q, 1'b0,
               in_divider_override_q, in_divider_ratio_q};
    end else if (reg_req.addr == `EQ_STAT_ADDR) begin
      rdata = {2'h0, eq_sync_q};
    end else if (reg_req.addr == `LINK_ERR_ADDR) begin
      rdata = {3'h0, err_count_enable_q, err_threshold_q};
    end else if (reg_req.addr == `CC_CFG_ADDR) begin
      rdata = cc_cfg_q;
    end else if (reg_req.addr == `EQ_FLOOR_ADDR) begin
      rdata = {4'h0, equalizer_floor_level_q};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      // read data holds until the next read is taken
      reg_rvalid_q <= reg_req_valid && !reg_req.write;
      if (reg_req_valid && !reg_req.write) begin
        reg_rdata_q <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // equalizer control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      eq_ctl_q <= '0;
    end else if (clk_en) begin
      // floor level shows zero whenever the floor is not applied
      eq_ctl_q.restart <= equalizer_adapt_restart_q;
      eq_ctl_q.floor_active <= floor_apply_q && floor_override_enable_q;
      eq_ctl_q.floor_level <= (floor_apply_q && floor_override_enable_q) ?
                              equalizer_floor_level_q : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // clock divider selection
  // ----------------------------------------------------------------
  // codes 4-5 and 6-7 share a ratio; 6-7 take the default
  function automatic logic [5:0] out_div_decode(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h01;
    case (code)
      3'h0: r = 6'h20;
      3'h1: r = 6'h10;
      3'h2: r = 6'h08;
      3'h3: r = 6'h04;
      3'h4, 3'h5: r = 6'h02;
      default: r = 6'h01;
    endcase
    return r;
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clk_div_q <= '0;
    end else if (clk_en) begin
      clk_div_q.out_div <= out_divider_override_q ?
        out_div_decode(out_divider_ratio_q) : auto_out_div;
      clk_div_q.in_div <= in_divider_override_q ?
        4'(4'h1 << in_divider_ratio_q) : auto_in_div;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_channel_mode_q <= 3'h0;
    end else if (clk_en) begin
      // only the mode field leaves the block; the rest is stored
      control_channel_mode_q <= cc_cfg_q[2:0];
    end
  end

  // ----------------------------------------------------------------
  // link error counter, pixel clock domain
  // ----------------------------------------------------------------
  // any channel in error counts once per cycle
  logic any_err;
  assign any_err = |err_sync_q;

  // errors only count while locked; an unlock restarts the tally
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      err_count_q <= 4'h0;
    end else if (clk_en) begin
      if (!link_locked) begin
        err_count_q <= 4'h0;
      end else if (any_err && err_count_enable_q &&
                   err_count_q + 4'h1 < err_threshold_q) begin
        err_count_q <= err_count_q + 4'h1;
      end
    end
  end

  // drop is a level that holds until the link is seen unlocked
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_drop_q <= 1'b0;
    end else if (clk_en) begin
      if (!link_locked) begin
        lock_drop_q <= 1'b0;
      end else if (any_err && !err_count_enable_q) begin
        lock_drop_q <= 1'b1;
      end else if (any_err && err_count_q + 4'h1 >= err_threshold_q) begin
        lock_drop_q <= 1'b1;
      end
    end
  end
endmodule

// *** rx_cfg_sva.sv ***
// port checker for the receiver configuration block
`include "rx_cfg_regs.svh"
module rx_cfg_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire rx_cfg_pkg::reg_req_t reg_req,
  input wire logic reg_req_valid,
  input wire logic reg_rvalid_q,
  input wire logic clk0_error,
  input wire logic clk1_error,
  input wire logic data_channel_error,
  input wire logic link_locked,
  input wire rx_cfg_pkg::eq_ctl_t eq_ctl_q,
  input wire rx_cfg_pkg::clk_div_t clk_div_q,
  input wire logic [2:0] control_channel_mode_q,
  input wire logic lock_drop_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import rx_cfg_pkg::*;
  logic rd_take, wr_take, err_any;
  assign rd_take = reg_req_valid && clk_en && !reg_req.write;
  assign wr_take = reg_req_valid && clk_en && reg_req.write;
  assign err_any = clk0_error | clk1_error | data_channel_error;
  function automatic logic [5:0] div_of(input logic [2:0] c);
    return (c >= 3'h6) ? 6'h01 : (c >= 3'h4) ? 6'h02 : 6'h20 >> c;
  endfunction
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_rvalid_cause: assert property (reg_rvalid_q |-> $past(rd_take))
    else $error("read answer without request");
  a_floor_gate: assert property (
    wr_take && reg_req.addr == `EQ_CTL_ADDR |-> ##2
    eq_ctl_q.floor_active == &$past(reg_req.wdata[5:4], 2))
    else $error("floor active wrong after write");
  a_floor_zero: assert property (
    !eq_ctl_q.floor_active |-> eq_ctl_q.floor_level == 4'h0)
    else $error("floor level shown while not applied");
  a_restart_kept: assert property ($fell(eq_ctl_q.restart) |->
    $past(wr_take && reg_req.addr == `EQ_CTL_ADDR, 2))
    else $error("restart cleared without write");
  a_out_div: assert property (
    wr_take && reg_req.addr == `ACLK_DIV_ADDR && reg_req.wdata[7] |->
    ##2 clk_div_q.out_div == div_of($past(reg_req.wdata[6:4], 2)))
    else $error("out divider decode wrong");
  a_in_div: assert property (
    wr_take && reg_req.addr == `ACLK_DIV_ADDR && reg_req.wdata[2] |->
    ##2 clk_div_q.in_div == 4'h1 << $past(reg_req.wdata[1:0], 2))
    else $error("in divider decode wrong");
  a_cc_mode: assert property (
    wr_take && reg_req.addr == `CC_CFG_ADDR |-> ##2
    control_channel_mode_q == $past(reg_req.wdata[2:0], 2))
    else $error("control channel mode wrong");
  a_drop_cause: assert property ($rose(lock_drop_q) |->
    $past(link_locked) && ($past(err_any, 2) || $past(err_any, 3) ||
    $past(err_any, 4)))
    else $error("lock drop without error");
  a_drop_hold: assert property (
    lock_drop_q && link_locked |=> lock_drop_q)
    else $error("lock drop released while locked");
  a_drop_clear: assert property (
    !link_locked && clk_en |=> !lock_drop_q)
    else $error("lock drop stays after unlock");
endmodule
bind receiver_equalizer_and_link_config rx_cfg_sva rx_cfg_sva_i (
  .clock, .rstn, .clk_en, .reg_req, .reg_req_valid, .reg_rvalid_q,
  .clk0_error, .clk1_error, .data_channel_error, .link_locked,
  .eq_ctl_q, .clk_div_q, .control_channel_mode_q, .lock_drop_q);

// *** receiver_equalizer_and_link_config_tb.sv ***
// register level testbench of the receiver configuration block
module receiver_equalizer_and_link_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_cfg_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, valid = 1'b0;
  logic link_locked = 1'b0, e0 = 1'b0, e1 = 1'b0, ed = 1'b0;
  reg_req_t req = '0;
  logic [5:0] auto_out = 6'h10;
  logic [3:0] auto_in = 4'h4;
  logic [7:0] rdata;
  logic rvalid, drop;
  eq_ctl_t eq;
  clk_div_t div;
  logic [2:0] cc, c;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam logic [5:0] ODIV [8] =
    '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};
  always #25 clock = ~clock;
  receiver_equalizer_and_link_config #(.STRAP_SETTLE(2))
    receiver_equalizer_and_link_config_i (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .reg_req(req),
    .reg_req_valid(valid), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .strap0_pin(3'h2), .strap1_pin(3'h5), .equalizer_setting(6'h2A),
    .auto_out_div(auto_out), .auto_in_div(auto_in), .clk0_error(e0),
    .clk1_error(e1), .data_channel_error(ed), .link_locked(link_locked),
    .eq_ctl_q(eq), .clk_div_q(div), .control_channel_mode_q(cc),
    .lock_drop_q(drop));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{write: w, addr: a, wdata: d};
    valid = 1'b1;
    @(negedge clock);
    valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rvalid, 1'b1);
    chk(rdata, exp);
  endtask
  // one-cycle error pulse on {clk0, clk1, data} then settle
  task automatic err(input logic [2:0] v);
    @(negedge clock);
    {e0, e1, ed} = v;
    @(negedge clock);
    {e0, e1, ed} = 3'h0;
    repeat (5) @(negedge clock);
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    repeat (8) @(negedge clock);
    rd(8'h35, 8'h00);
    rd(8'h41, 8'h03);
    rd(8'h45, 8'h08);
    rd(8'h3B, 8'h2A);
    rd(8'h50, 8'h00);
    rd(8'h37, 8'hDA);
    acc(1'b1, 8'h37, 8'h00);
    rd(8'h37, 8'hDA);
    chk(div, {auto_out, auto_in});
    acc(1'b1, 8'h35, 8'hFF);
    rd(8'h35, 8'h70);
    repeat (8) @(negedge clock);
    chk(eq, {2'b11, 4'h8});
    acc(1'b1, 8'h45, 8'hF5);
    rd(8'h45, 8'h05);
    chk(eq.floor_level, 4'h5);
    acc(1'b1, 8'h35, 8'h10);
    repeat (2) @(negedge clock);
    chk(eq, 6'h00);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      acc(1'b1, 8'h3A, {1'b1, c, 2'b11, c[1:0]});
      rd(8'h3A, {1'b1, c, 2'b01, c[1:0]});
      chk(div.out_div, ODIV[i]);
      chk(div.in_div, 4'h1 << c[1:0]);
    end
    acc(1'b1, 8'h3A, 8'h73);
    auto_out = 6'h08;
    auto_in = 4'h2;
    repeat (3) @(negedge clock);
    chk(div, {6'h08, 4'h2});
    acc(1'b1, 8'h43, 8'hFF);
    rd(8'h43, 8'h1F);
    chk(cc, 3'h7);
    link_locked = 1'b1;
    err(3'h1);
    chk(drop, 1'b1);
    link_locked = 1'b0;
    repeat (2) @(negedge clock);
    chk(drop, 1'b0);
    link_locked = 1'b1;
    acc(1'b1, 8'h41, 8'hF3);
    rd(8'h41, 8'h13);
    err(3'h4);
    err(3'h2);
    chk(drop, 1'b0);
    err(3'h1);
    chk(drop, 1'b1);
    @(negedge clock);
    clk_en = 1'b0;
    req = '{write: 1'b0, addr: 8'h41, wdata: 8'h00};
    valid = 1'b1;
    @(negedge clock);
    valid = 1'b0;
    clk_en = 1'b1;
    chk(rvalid, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    rd(8'h41, 8'h03);
    rd(8'h43, 8'h00);
    chk(drop, 1'b0);
    stop_test();
  end
endmodule
